// *** design/prp_pattern_player.sv ***
// pattern memory loader and symbol player with a wishbone register port
// assumes a classic wishbone master on clk_i and one 50 MHz clock
`include "prp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module prp_pattern_player
  import prp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // signal outputs
  output logic             rf_on_o,
  output logic             data_o,
  output logic             marker_o
);

  function automatic logic [`PRP_CNT_W-1:0] cap_words(input logic [1:0] o);
    unique case (o)
      2'd0:    cap_words = `PRP_CAP_OPT0;
      2'd1:    cap_words = `PRP_CAP_OPT1;
      default: cap_words = `PRP_CAP_OPT2;
    endcase
  endfunction

  // reserved bits must read xx010x0x; anything else is only flagged,
  // the byte is still stored so the download count stays honest
  function automatic logic byte_ok(input logic [7:0] b);
    byte_ok = ((b & `PRP_FIXED_MASK) == `PRP_FIXED_VAL);
  endfunction

  logic [31:0] mem [0:`PRP_DEPTH-1];

  prp_state_t              st_q, st_d;
  logic                    ack_q, ack_d;
  logic [31:0]             rdat_q, rdat_d;
  logic                    run_q, run_d;
  logic [1:0]              opt_q, opt_d;
  logic [15:0]             rate_q, rate_d;
  logic [15:0]             div_q, div_d;
  logic                    tick_q, tick_d;
  logic [`PRP_CNT_W-1:0]   cnt_q, cnt_d;
  logic                    ovf_q, ovf_d;
  logic                    perr_q, perr_d;
  logic                    bad_q, bad_d;
  logic [8:0]              acc_q, acc_d;
  logic [31:0]             sum_q, sum_d;
  logic [7:0]              reps_q, reps_d;
  logic [7:0]              rep_i_q, rep_i_d;
  logic [`PRP_AW-1:0]      ptr_q, ptr_d;
  logic [31:0]             word_q;
  logic [`PRP_BURST_LAG-1:0] lag_q, lag_d;
  prp_out_t                out_q, out_d;
  logic                    wr_en;
  logic [7:0]              wr_byte;

  wire logic acc_en  = cyc_i && stb_i && !ack_q;
  wire logic wr_acc  = acc_en && we_i && sel_i[0];
  prp_word_t cur;
  assign cur = prp_word_t'(word_q);

  // bus answer: one-cycle ack, never two in a row
  always_comb begin
    ack_d = acc_en;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_comb begin
    st_d    = st_q;
    rdat_d  = rdat_q;
    run_d   = run_q;
    opt_d   = opt_q;
    rate_d  = rate_q;
    div_d   = div_q;
    tick_d  = 1'b0;
    cnt_d   = cnt_q;
    ovf_d   = ovf_q;
    perr_d  = perr_q;
    bad_d   = bad_q;
    acc_d   = acc_q;
    sum_d   = sum_q;
    reps_d  = reps_q;
    rep_i_d = rep_i_q;
    ptr_d   = ptr_q;
    lag_d   = lag_q;
    out_d   = out_q;
    wr_en   = 1'b0;
    wr_byte = 8'h00;
    // status flags: software clear first, hardware set wins below
    if (wr_acc && adr_i == `PRP_OFS_STATUS) begin
      if (dat_i[`PRP_ST_OVF])     ovf_d  = 1'b0;
      if (dat_i[`PRP_ST_PARSE])   perr_d = 1'b0;
      if (dat_i[`PRP_ST_BADBYTE]) bad_d  = 1'b0;
    end
    if (wr_acc && adr_i == `PRP_OFS_CTRL) begin
      run_d = dat_i[`PRP_CTRL_RUN];
      opt_d = dat_i[`PRP_CTRL_OPT_LO+:2];
      if (dat_i[`PRP_CTRL_CLEAR] && st_q == PRP_IDLE) begin
        cnt_d = '0;
        acc_d = '0;
      end
    end
    if (wr_acc && adr_i == `PRP_OFS_RATE) begin
      rate_d = dat_i[15:0];
    end
    // download only while stopped; writes during playback are dropped
    if (wr_acc && st_q == PRP_IDLE) begin
      if (adr_i == `PRP_OFS_DATA) begin
        wr_en   = 1'b1;
        wr_byte = dat_i[7:0];
      end else if (adr_i == `PRP_OFS_LIST) begin
        if (dat_i[7:0] >= 8'h30 && dat_i[7:0] <= 8'h39) begin
          acc_d = 9'(acc_q * 9'd10 + 9'(dat_i[7:0] - 8'h30));
          if (acc_q > 9'd25 || acc_d > 9'd255) perr_d = 1'b1;
        end else if (dat_i[7:0] == 8'h2c || dat_i[7:0] == 8'h0a) begin
          wr_en   = 1'b1;
          wr_byte = acc_q[7:0];
          acc_d   = '0;
        end else if (dat_i[7:0] != 8'h20) begin
          perr_d = 1'b1;
        end
      end
    end
    if (wr_en) begin
      if (cnt_q >= cap_words(opt_q) || cnt_q >= `PRP_CNT_W'(`PRP_DEPTH)) begin
        wr_en = 1'b0;
        ovf_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
        if (!byte_ok(wr_byte)) bad_d = 1'b1;
      end
    end
    // symbol-rate enable
    if (div_q == 16'h0000) begin
      div_d  = rate_q;
      tick_d = (st_q == PRP_PLAY);
    end else begin
      div_d = div_q - 1'b1;
    end
    out_d.marker = 1'b0;
    unique case (st_q)
      PRP_IDLE: begin
        out_d.rf_on = 1'b0;
        out_d.data  = 1'b0;
        lag_d       = '0;
        if (run_q && cnt_q != '0) begin
          st_d   = PRP_CALC;
          sum_d  = '0;
          reps_d = '0;
        end
      end
      PRP_CALC: begin
        // ceiling by repeated add: reps grows until sixty downloaded
        // bytes are met; one byte per word, so cnt counts bytes here.
        // worst case is a one-byte file: sixty adds, no divider needed
        if (sum_q >= 32'(`PRP_MIN_BYTES)) begin
          st_d    = PRP_PLAY;
          ptr_d   = '0;
          rep_i_d = '0;
          div_d   = rate_q;
        end else begin
          sum_d  = sum_q + 32'(cnt_q);
          reps_d = reps_q + 1'b1;
        end
      end
      PRP_PLAY: begin
        if (!run_q) begin
          st_d = PRP_IDLE;
        end else if (tick_q) begin
          lag_d = {lag_q[`PRP_BURST_LAG-2:0], cur.pbyte.burst};
          out_d.rf_on  = lag_q[`PRP_BURST_LAG-1];
          out_d.data   = cur.pbyte.data & cur.pbyte.burst;
          out_d.marker = cur.pbyte.marker;
          if (cur.pbyte.restart || 27'(ptr_q) + 1'b1 >= cnt_q) begin
            ptr_d   = '0;
            rep_i_d = (rep_i_q + 1'b1 >= reps_q) ? 8'h00 : rep_i_q + 1'b1;
          end else begin
            ptr_d = ptr_q + 1'b1;
          end
        end
      end
    endcase
    if (acc_en && !we_i) begin
      unique case (adr_i)
        `PRP_OFS_CTRL:   rdat_d = {28'h0, opt_q, 1'b0, run_q};
        `PRP_OFS_STATUS: rdat_d = {28'h0, bad_d, perr_d, ovf_d,
                                   st_q == PRP_PLAY};
        `PRP_OFS_COUNT:  rdat_d = 32'(cnt_q);
        `PRP_OFS_SIZE:   rdat_d = 32'({cnt_q, 2'b00});
        `PRP_OFS_REPS:   rdat_d = {16'h0, rep_i_q, reps_q};
        `PRP_OFS_RATE:   rdat_d = {16'h0, rate_q};
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // store expanded word; own bits sit above the downloaded byte
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[cnt_q[`PRP_AW-1:0]] <= {`PRP_OWN_BITS, wr_byte};
    end
    word_q <= mem[ptr_d];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= PRP_IDLE;
      rdat_q  <= 32'h0000_0000;
      run_q   <= 1'b0;
      opt_q   <= 2'h0;
      rate_q  <= `PRP_RATE_RST;
      div_q   <= 16'h0000;
      tick_q  <= 1'b0;
      cnt_q   <= '0;
      ovf_q   <= 1'b0;
      perr_q  <= 1'b0;
      bad_q   <= 1'b0;
      acc_q   <= '0;
      sum_q   <= 32'h0000_0000;
      reps_q  <= 8'h00;
      rep_i_q <= 8'h00;
      ptr_q   <= '0;
      lag_q   <= '0;
      out_q   <= '0;
    end else begin
      st_q    <= st_d;
      rdat_q  <= rdat_d;
      run_q   <= run_d;
      opt_q   <= opt_d;
      rate_q  <= rate_d;
      div_q   <= div_d;
      tick_q  <= tick_d;
      cnt_q   <= cnt_d;
      ovf_q   <= ovf_d;
      perr_q  <= perr_d;
      bad_q   <= bad_d;
      acc_q   <= acc_d;
      sum_q   <= sum_d;
      reps_q  <= reps_d;
      rep_i_q <= rep_i_d;
      ptr_q   <= ptr_d;
      lag_q   <= lag_d;
      out_q   <= out_d;
    end
  end

  assign dat_o    = rdat_q;
  assign ack_o    = ack_q;
  assign rf_on_o  = out_q.rf_on;
  assign data_o   = out_q.data;
  assign marker_o = out_q.marker;

endmodule

`default_nettype wire

// *** design/prp_defs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the player module and its package users only
`ifndef PRP_DEFS_SVH
`define PRP_DEFS_SVH

`define PRP_CLK_HZ        50000000
`define PRP_ADDR_W        5
`define PRP_OFS_CTRL      5'h00
`define PRP_OFS_STATUS    5'h04
`define PRP_OFS_DATA      5'h08
`define PRP_OFS_LIST      5'h0c
`define PRP_OFS_COUNT     5'h10
`define PRP_OFS_SIZE      5'h14
`define PRP_OFS_REPS      5'h18
`define PRP_OFS_RATE      5'h1c

`define PRP_CTRL_RUN      0
`define PRP_CTRL_CLEAR    1
`define PRP_CTRL_OPT_LO   2
`define PRP_ST_PLAY       0
`define PRP_ST_OVF        1
`define PRP_ST_PARSE      2
`define PRP_ST_BADBYTE    3

`define PRP_BIT_DATA      0
`define PRP_BIT_BURST     2
`define PRP_BIT_MARK      6
`define PRP_BIT_RESTART   7
`define PRP_FIXED_MASK    8'h3a
`define PRP_FIXED_VAL     8'h10

`define PRP_WORD_BYTES    4
`define PRP_MIN_BYTES     60
`define PRP_BURST_LAG     12
`define PRP_OWN_BITS      24'h000000
`define PRP_DEPTH         4096
`define PRP_AW            12
`define PRP_CNT_W         27
`define PRP_CAP_OPT0      27'd8388608
`define PRP_CAP_OPT1      27'd33554432
`define PRP_CAP_OPT2      27'd67108864
`define PRP_RATE_RST      16'h0031

`endif

// *** design/prp_pkg.sv ***
// types shared by the pattern player
// assumes prp_defs.svh is on the include path
package prp_pkg;
  typedef enum logic [1:0] {
    PRP_IDLE,
    PRP_CALC,
    PRP_PLAY
  } prp_state_t;

  typedef struct packed {
    logic restart;
    logic marker;
    logic fixed5;
    logic fixed4;
    logic fixed3;
    logic burst;
    logic fixed1;
    logic data;
  } prp_byte_t;

  typedef struct packed {
    logic [23:0] own;
    prp_byte_t   pbyte;
  } prp_word_t;

  typedef struct packed {
    logic rf_on;
    logic data;
    logic marker;
  } prp_out_t;
endpackage

// *** testbench/prp_pattern_player_assertions.sv ***
// port timing checker for the pattern player
// assumes a bind from the bench top onto prp_pattern_player
`timescale 1ns/1ps
`default_nettype none
module prp_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // signal outputs
  input wire logic        rf_on_o,
  input wire logic        data_o,
  input wire logic        marker_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack while bus idle");
  chk_marker_one: assert property (marker_o |=> !marker_o)
    else $error("marker pulse wider than one clock");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !(ack_o || rf_on_o
    || data_o || marker_o))
    else $error("output active right after reset");
  chk_size_quad: assert property (ack_o && !we_i && adr_i == 5'h14 |->
    dat_o[1:0] == 2'b00)
    else $error("size not a whole number of words");
  chk_count_cap: assert property (ack_o && !we_i && adr_i == 5'h10 |->
    dat_o <= 32'd4096)
    else $error("count beyond memory depth");
endmodule
`default_nettype wire

// *** testbench/prp_wb_host.sv ***
// controller model: classic wishbone master that downloads patterns
// assumes the bench calls xfer just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module prp_wb_host (
  // clock and bus answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  // bus request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [4:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 5'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released data no longer shows the last value
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** testbench/prp_pattern_player_tb.sv ***
// self-checking bench for the pattern player
// assumes prp_pkg, the player and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module prp_pattern_player_tb;
  import prp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, rf_on, data, marker;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, m, r;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  prp_byte_t   pat[14];
  int          errors = 0;
  int          n_compared = 0;
  integer      seed = 32'h473f9bb9;
  time         t0;
  always #10 clk_i = ~clk_i;
  prp_wb_host host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  prp_pattern_player uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .rf_on_o(rf_on), .data_o(data),
    .marker_o(marker));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] k = 32'hffffffff);
    expq.push_back(e);
    mskq.push_back(k);
    host.xfer(1'b0, a, 32'h0);
  endtask
  // read data is taken at the edge that samples ack high
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      m = mskq.pop_front();
      check(rdat & m, expq.pop_front() & m);
    end
  end
  initial begin
    #1000000;
    errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(5'h1c, 32'h31);
    rd(5'h10, 32'h0);
    rd(5'h04, 32'h0);
    rd(5'h1d, 32'h0);
    wr(5'h1c, 32'h1);
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      pat[i] = 8'h10;
      pat[i].data = r[0];
      pat[i].burst = r[1];
      pat[i].marker = (i == 0);
      pat[i].restart = (i == 13);
      wr(5'h08, {24'h0, pat[i]});
    end
    rd(5'h10, 32'd14);
    rd(5'h14, 32'd56);
    wr(5'h00, 32'h1);
    repeat (70) @(posedge clk_i);
    rd(5'h18, 32'd5, 32'hff);
    rd(5'h04, 32'h1, 32'h1);
    wr(5'h08, 32'h15);
    rd(5'h10, 32'd14);
    @(posedge marker);
    t0 = $time;
    @(negedge clk_i);
    for (int k = 0; k < 14; k++) begin
      check({31'h0, data}, {31'h0, pat[k].data & pat[k].burst});
      check({31'h0, rf_on}, {31'h0, pat[(k + 2) % 14].burst});
      check({31'h0, marker}, {31'h0, k == 0});
      if (k < 13) repeat (2) @(negedge clk_i);
    end
    @(posedge marker);
    check(32'($time - t0), 32'd560);
    @(posedge clk_i);
    wr(5'h00, 32'h0);
    wr(5'h00, 32'h2);
    rd(5'h10, 32'h0);
    wr(5'h0c, 32'h32);
    wr(5'h0c, 32'h31);
    wr(5'h0c, 32'h2c);
    rd(5'h10, 32'd1);
    rd(5'h04, 32'h0, 32'h4);
    wr(5'h08, 32'h01);
    for (int i = 2; i < 4096; i++) wr(5'h08, 32'h10);
    wr(5'h08, 32'h10);
    rd(5'h04, 32'ha, 32'ha);
    rd(5'h10, 32'd4096);
    give_verdict;
  end
endmodule
bind prp_pattern_player prp_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rf_on_o(rf_on_o),
  .data_o(data_o), .marker_o(marker_o));
`default_nettype wire
